// ==== hdl/fec_ctrl.sv ====
// host-side command sequencer for a parallel x16 nor flash
// assumes: one command request at a time on cmd_*; flash pins wired directly
`timescale 1ns/10ps
module fec_ctrl
   import fec_pkg::*;
#(
   parameter int POLL_LIMIT = PROG_MAX_CYC * 4096
)
(
   input  wire logic                    sys_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    cmd_valid,
   input  wire fec_pkg::fec_op_t        cmd_op,
   input  wire logic [fec_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [fec_pkg::DATA_W-1:0] cmd_data,
   output logic                         cmd_ready,
   output logic                         rsp_valid,
   output logic                         rsp_ok,
   output logic [fec_pkg::DATA_W-1:0]   rsp_data,
   output logic                         mode_query,
   output logic                         mode_id,
   output logic                         flash_ce_n,
   output logic                         flash_oe_n,
   output logic                         flash_we_n,
   output logic [fec_pkg::ADDR_W-1:0]   flash_addr,
   output logic [fec_pkg::DATA_W-1:0]   flash_dq_o,
   output logic                         flash_dq_oe,
   input  wire logic [fec_pkg::DATA_W-1:0] flash_dq_i
);
   import fec_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_WRITE, S_POLL, S_SETTLE, S_CONFIRM, S_READ, S_RESP
   } fec_state_t;

   fec_bus_if bus ();

   fec_state_t           st_q;
   fec_op_t              op_q;
   logic [ADDR_W-1:0]    addr_q;
   logic [DATA_W-1:0]    data_q;
   logic [2:0]           step_q;
   logic [2:0]           nsteps_q;
   logic                 req_q;
   logic                 wait_q;
   logic [DATA_W-1:0]    prev_q;
   logic                 have_prev_q;
   logic [1:0]           conf_q;
   logic [31:0]          tmo_q;
   logic [15:0]          settle_q;
   logic                 fail_q;

   // number of write cycles a command needs [R16]
   function automatic logic [2:0] fec_steps(input fec_op_t op);
      case (op)
         FEC_OP_PROGRAM: fec_steps = 3'd4;
         // id entry, vendor query and the long exit are the two-cycle prefix plus one code, three cycles [R18] [R26]
         FEC_OP_ID_ENTRY, FEC_OP_VQUERY, FEC_OP_EXIT_LONG: fec_steps = 3'd3;
         FEC_OP_SECTOR, FEC_OP_BLOCK, FEC_OP_CHIP: fec_steps = 3'd6;
         FEC_OP_GQUERY, FEC_OP_EXIT_SHORT: fec_steps = 3'd1;
         default: fec_steps = 3'd0;
      endcase
   endfunction : fec_steps

   function automatic logic fec_is_erase(input fec_op_t op);
      fec_is_erase = (op == FEC_OP_SECTOR) || (op == FEC_OP_BLOCK) || (op == FEC_OP_CHIP);
   endfunction : fec_is_erase

   // address and code of one write cycle of a sequence [R25]
   function automatic logic [ADDR_W+DATA_W-1:0] fec_cycle_word(
      input fec_op_t op, input logic [2:0] step,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [ADDR_W-1:0] ca;
      logic [7:0]        cd;
      ca = ADDR_W'(ADDR_UNLOCK1);
      cd = CODE_AA;
      if (op == FEC_OP_GQUERY) begin
         ca = ADDR_W'(ADDR_GENQUERY);           // [R19]
         cd = CODE_QUERY;
      end else if (op == FEC_OP_EXIT_SHORT) begin
         ca = ADDR_W'(ADDR_UNLOCK1);            // [R26]
         cd = CODE_EXIT;
      end else begin
         case (step)
            3'd0, 3'd3: begin
               ca = ADDR_W'(ADDR_UNLOCK1);
               cd = CODE_AA;
            end
            3'd1, 3'd4: begin
               ca = ADDR_W'(ADDR_UNLOCK2);
               cd = CODE_55;
            end
            3'd2: begin
               ca = ADDR_W'(ADDR_UNLOCK1);
               case (op)
                  FEC_OP_PROGRAM:   cd = CODE_PROG;
                  FEC_OP_ID_ENTRY:  cd = CODE_ID;
                  FEC_OP_VQUERY:    cd = CODE_QUERY;   // [R18]
                  FEC_OP_EXIT_LONG: cd = CODE_EXIT;    // [R26]
                  default:          cd = CODE_ERASE;
               endcase
            end
            default: begin
               // final cycle: program word, or sector/block erase code with target, chip erase code at 5555H [R01] [R02] [R05]
               ca = a;
               cd = 8'h00;
               case (op)
                  FEC_OP_SECTOR: cd = CODE_SECTOR;
                  FEC_OP_BLOCK:  cd = CODE_BLOCK;
                  FEC_OP_CHIP: begin
                     ca = ADDR_W'(ADDR_UNLOCK1);
                     cd = CODE_CHIP;
                  end
                  default: ;
               endcase
            end
         endcase
      end
      if (op == FEC_OP_PROGRAM && step == 3'd3)
         fec_cycle_word = {a, d};
      else
         fec_cycle_word = {ca, 8'h00, cd};
   endfunction : fec_cycle_word

   logic [ADDR_W+DATA_W-1:0] cw;
   assign cw = fec_cycle_word(op_q, step_q, addr_q, data_q);

   fec_cycle u_cycle (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .bus     (bus.cyc),
      .ce_n    (flash_ce_n),
      .oe_n    (flash_oe_n),
      .we_n    (flash_we_n),
      .addr    (flash_addr),
      .dq_o    (flash_dq_o),
      .dq_oe   (flash_dq_oe),
      .dq_i    (flash_dq_i)
   );

   assign bus.req   = req_q;
   assign bus.wr    = (st_q == S_WRITE);
   assign bus.addr  = (st_q == S_WRITE) ? cw[ADDR_W+DATA_W-1:DATA_W] : addr_q;
   assign bus.wdata = cw[DATA_W-1:0];

   // a status word is done when polarity shows truth and the other bit stopped
   logic done_match;
   logic [DATA_W-1:0] target_w;
   assign target_w = fec_is_erase(op_q) ? {DATA_W{1'b1}} : data_q;
   assign done_match = (bus.rdata[POLARITY_BIT] == target_w[POLARITY_BIT])   // [R08] [R10]
                    && have_prev_q
                    && (bus.rdata[ALTERNATING_BIT] == prev_q[ALTERNATING_BIT]); // [R12]

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= S_IDLE;
         op_q <= FEC_OP_READ;
         addr_q <= '0;
         data_q <= '0;
         step_q <= 3'd0;
         nsteps_q <= 3'd0;
         req_q <= 1'b0;
         wait_q <= 1'b0;
         prev_q <= '0;
         have_prev_q <= 1'b0;
         conf_q <= 2'd0;
         tmo_q <= '0;
         settle_q <= '0;
         fail_q <= 1'b0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_ok <= 1'b0;
         rsp_data <= '0;
      end else begin
         rsp_valid <= 1'b0;
         req_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  op_q <= cmd_op;
                  addr_q <= cmd_addr;
                  data_q <= cmd_data;
                  step_q <= 3'd0;
                  nsteps_q <= fec_steps(cmd_op);
                  fail_q <= 1'b0;
                  have_prev_q <= 1'b0;
                  conf_q <= 2'd0;
                  tmo_q <= '0;
                  req_q <= 1'b1;
                  st_q <= (fec_steps(cmd_op) == 3'd0) ? S_READ : S_WRITE;
               end
            end
            S_WRITE: begin
               // whole sequence issued back to back, never a bare alteration [R16]
               if (bus.done) begin
                  if (step_q + 3'd1 == nsteps_q) begin
                     // status is polled only once the last pulse has risen [R11]
                     if (op_q == FEC_OP_PROGRAM || fec_is_erase(op_q)) begin
                        req_q <= 1'b1;
                        st_q <= S_POLL;
                     end else
                        st_q <= S_RESP;
                  end else begin
                     step_q <= step_q + 3'd1;
                     req_q <= 1'b1;
                  end
               end
            end
            S_POLL: begin
               // only status reads while busy; no command is sent meanwhile [R04] [R07] [R22]
               tmo_q <= tmo_q + 32'd1;
               if (bus.done) begin
                  prev_q <= bus.rdata;
                  have_prev_q <= 1'b1;
                  if (done_match) begin
                     conf_q <= 2'd0;
                     st_q <= S_CONFIRM;
                  end else if (tmo_q >= 32'(POLL_LIMIT)) begin
                     fail_q <= 1'b1;                     // program or erase overran its bound [R24]
                     st_q <= S_RESP;
                  end
                  req_q <= ~done_match && (tmo_q < 32'(POLL_LIMIT));
                  if (done_match) req_q <= 1'b1;
               end
            end
            S_CONFIRM: begin
               // two further reads must both agree before completion is believed [R13]
               if (bus.done) begin
                  prev_q <= bus.rdata;
                  if (!done_match) begin
                     req_q <= 1'b1;
                     st_q <= S_POLL;
                  end else if (conf_q + 2'd1 == 2'(CONFIRM_READS)) begin
                     settle_q <= 16'(SETTLE_CYC);
                     st_q <= S_SETTLE;
                  end else begin
                     conf_q <= conf_q + 2'd1;
                     req_q <= 1'b1;
                  end
               end
            end
            S_SETTLE: begin
               // remaining data bits are trusted only after the settling wait [R09]
               if (settle_q > 16'd1) settle_q <= settle_q - 16'd1;
               else begin
                  req_q <= 1'b1;
                  st_q <= S_READ;
               end
            end
            S_READ: begin
               if (bus.done) begin
                  rsp_data <= bus.rdata;
                  if (op_q == FEC_OP_PROGRAM)
                     fail_q <= (bus.rdata != data_q);
                  else if (fec_is_erase(op_q))
                     fail_q <= 1'b0;
                  st_q <= S_RESP;
               end
            end
            S_RESP: begin
               rsp_valid <= 1'b1;
               rsp_ok <= ~fail_q;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // mirror of the device read mode; id words at 0000H/0001H read via FEC_OP_READ [R21]
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_query <= 1'b0;
         mode_id <= 1'b0;
      end else if (st_q == S_RESP) begin
         case (op_q)
            FEC_OP_VQUERY, FEC_OP_GQUERY: mode_query <= 1'b1;    // [R20]
            FEC_OP_ID_ENTRY: mode_id <= 1'b1;
            FEC_OP_EXIT_SHORT, FEC_OP_EXIT_LONG: begin
               mode_query <= 1'b0;                            // [R22]
               mode_id <= 1'b0;
            end
            default: ;
         endcase
      end
   end
endmodule : fec_ctrl

// ==== common/fec_pkg.sv ====
// package for the flash erase/status command controller (host side)
// assumes: 250 MHz sys_clk, an asynchronous parallel x16 flash on the pins
// Notes on behaviour
// R01 - sector erase: six writes, last 30H
// R02 - block erase: six writes, last 50H
// R03 - device latches address and code, sixth pulse
// R04 - device ignores commands during erase
// R05 - chip erase: six writes, 10H at 5555H
// R06 - chip erase starts at sixth rising edge
// R07 - during erase reads give status only
// R08 - program polling bit reads inverted data
// R09 - full word valid 1 us later
// R10 - erase polling bit 0, then 1
// R11 - status valid after fourth/sixth pulse
// R12 - alternating bit toggles until done
// R13 - on mismatch read twice more, confirm
// R14 - strobe glitch under 5 ns ignored
// R15 - no write with gate low or strobes high
// R16 - program needs prefix, erase six cycles
// R17 - bad unlock code aborts to read mode
// R18 - vendor query: prefix then 98H at 5555H
// R19 - generic query: 98H at 55H
// R20 - query mode held until exit command
// R21 - id reads at 0000H and 0001H
// R22 - exit recovers, ignored while busy
// R23 - address latched late fall, data early rise
// R24 - program finishes within 40 us
// R25 - prefix AAH/5555H, 55H/2AAAH, 15-bit compare
// R26 - exit: single F0H or prefix plus F0H
package fec_pkg;
   localparam int CLK_MHZ        = 250;
   localparam int ADDR_W         = 19;
   localparam int DATA_W         = 16;
   localparam int ADDR_UNLOCK1   = 'h5555;
   localparam int ADDR_UNLOCK2   = 'h2AAA;
   localparam int ADDR_GENQUERY  = 'h55;
   localparam logic [7:0] CODE_AA     = 8'hAA;
   localparam logic [7:0] CODE_55     = 8'h55;
   localparam logic [7:0] CODE_PROG   = 8'hA0;
   localparam logic [7:0] CODE_ERASE  = 8'h80;
   localparam logic [7:0] CODE_SECTOR = 8'h30;
   localparam logic [7:0] CODE_BLOCK  = 8'h50;
   localparam logic [7:0] CODE_CHIP   = 8'h10;
   localparam logic [7:0] CODE_ID     = 8'h90;
   localparam logic [7:0] CODE_QUERY  = 8'h98;
   localparam logic [7:0] CODE_EXIT   = 8'hF0;
   localparam int POLARITY_BIT    = 7;
   localparam int ALTERNATING_BIT = 6;
   // pin timing, in ns
   localparam int T_SETUP_NS  = 20;
   localparam int T_WPULSE_NS = 40;
   localparam int T_READ_NS   = 80;
   localparam int T_SETTLE_NS = 1000;
   localparam int T_PROG_MAX_NS = 40000;
   localparam int SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int WPULSE_CYC = (T_WPULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_CYC   = (T_READ_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int PROG_MAX_CYC = (T_PROG_MAX_NS * CLK_MHZ) / 1000;
   localparam int CONFIRM_READS = 2;

   typedef enum logic [3:0] {
      FEC_OP_PROGRAM, FEC_OP_SECTOR, FEC_OP_BLOCK, FEC_OP_CHIP,
      FEC_OP_ID_ENTRY, FEC_OP_VQUERY, FEC_OP_GQUERY,
      FEC_OP_EXIT_SHORT, FEC_OP_EXIT_LONG, FEC_OP_READ
   } fec_op_t;
endpackage : fec_pkg

// ==== common/fec_bus_if.sv ====
// carrier between the sequencer and the pin cycle engine
// assumes: one clock domain, single request outstanding
`timescale 1ns/10ps
interface fec_bus_if;
   import fec_pkg::*;
   logic                req;
   logic                wr;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wdata;
   logic                done;
   logic [DATA_W-1:0]   rdata;
   modport seq (output req, output wr, output addr, output wdata,
                input done, input rdata);
   modport cyc (input req, input wr, input addr, input wdata,
                output done, output rdata);
endinterface : fec_bus_if

// ==== hdl/fec_cycle.sv ====
// one flash bus cycle at a time: write strobe pulse or gated read
// assumes: flash pins are driven only from here; timings from fec_pkg
`timescale 1ns/10ps
module fec_cycle
   import fec_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   fec_bus_if.cyc                 bus,
   output logic                   ce_n,
   output logic                   oe_n,
   output logic                   we_n,
   output logic [ADDR_W-1:0]      addr,
   output logic [DATA_W-1:0]      dq_o,
   output logic                   dq_oe,
   input  wire logic [DATA_W-1:0] dq_i
);
   import fec_pkg::*;
   typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD, CY_DONE} fec_cy_t;
   fec_cy_t   st_q;
   logic [7:0] cnt_q;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= CY_IDLE;
         cnt_q <= 8'h00;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         dq_oe <= 1'b0;
         addr <= '0;
         dq_o <= '0;
         bus.done <= 1'b0;
         bus.rdata <= '0;
      end else begin
         bus.done <= 1'b0;
         case (st_q)
            CY_IDLE: begin
               if (bus.req) begin
                  // address and data settle before the strobes fall [R23]
                  addr <= bus.addr;
                  dq_o <= bus.wdata;
                  dq_oe <= bus.wr;
                  ce_n <= 1'b0;
                  oe_n <= 1'b1;
                  cnt_q <= 8'(SETUP_CYC);
                  st_q <= CY_SETUP;
               end
            end
            CY_SETUP: begin
               if (cnt_q > 8'h01) cnt_q <= cnt_q - 8'h01;
               else begin
                  // write only with gate high and select low [R15]
                  we_n <= ~bus.wr;
                  oe_n <= bus.wr;
                  cnt_q <= bus.wr ? 8'(WPULSE_CYC) : 8'(READ_CYC);
                  st_q <= CY_PULSE;
               end
            end
            CY_PULSE: begin
               // strobe low far longer than the glitch filter [R14]
               if (cnt_q > 8'h01) cnt_q <= cnt_q - 8'h01;
               else begin
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  bus.rdata <= dq_i;
                  cnt_q <= 8'(SETUP_CYC);
                  st_q <= CY_HOLD;
               end
            end
            CY_HOLD: begin
               // data held past the rising edge that latches it [R23]
               if (cnt_q > 8'h01) cnt_q <= cnt_q - 8'h01;
               else begin
                  ce_n <= 1'b1;
                  dq_oe <= 1'b0;
                  st_q <= CY_DONE;
               end
            end
            CY_DONE: begin
               bus.done <= 1'b1;
               st_q <= CY_IDLE;
            end
            default: st_q <= CY_IDLE;
         endcase
      end
   end
endmodule : fec_cycle

// ==== sim/fec_ctrl_sva.sv ====
// pin and handshake checks for the flash command controller
// assumes: bound to fec_ctrl, single sys_clk domain
`timescale 1ns/10ps
module fec_ctrl_sva
   import fec_pkg::*;
#(
   parameter int POLL_LIMIT = 200
)
(
   input wire logic                      sys_clk,
   input wire logic                      sys_rst,
   input wire logic                      cmd_valid,
   input wire fec_pkg::fec_op_t          cmd_op,
   input wire logic                      cmd_ready,
   input wire logic                      rsp_valid,
   input wire logic                      flash_ce_n,
   input wire logic                      flash_oe_n,
   input wire logic                      flash_we_n,
   input wire logic [fec_pkg::ADDR_W-1:0] flash_addr,
   input wire logic [fec_pkg::DATA_W-1:0] flash_dq_o,
   input wire logic                      flash_dq_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_take_gq;
      cmd_valid && cmd_ready && cmd_op == FEC_OP_GQUERY;
   endsequence
   sequence s_gq_write;
      ##[1:40] (!flash_we_n && flash_addr[14:0] == 15'h0055 && flash_dq_o[7:0] == 8'h98);
   endsequence
   a_we_needs_ce: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
      else $error("write strobe without select or with gate low");
   a_we_drives_dq: assert property (!flash_we_n |-> flash_dq_oe)
      else $error("write strobe while data not driven");
   a_read_released: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
      else $error("read gate while host drives data or unselected");
   a_we_min_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*2])
      else $error("write strobe pulse too short");
   a_write_held: assert property (!flash_we_n && !$past(flash_we_n)
      |-> $stable(flash_addr) && $stable(flash_dq_o))
      else $error("address or data moved during strobe");
   a_we_rise_sel: assert property ($rose(flash_we_n) |-> !flash_ce_n)
      else $error("select released before strobe end");
   a_take_drops: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready stayed high after take");
   a_rsp_not_ready: assert property (rsp_valid |-> !cmd_ready)
      else $error("ready high with response");
   a_gq_single: assert property (s_take_gq |-> s_gq_write)
      else $error("generic query write missing");
endmodule : fec_ctrl_sva

bind fec_ctrl fec_ctrl_sva #(.POLL_LIMIT(POLL_LIMIT)) u_sva (.sys_clk, .sys_rst, .cmd_valid,
   .cmd_op, .cmd_ready, .rsp_valid, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr,
   .flash_dq_o, .flash_dq_oe);

// ==== sim/fec_flash_model.sv ====
// behavioural x16 nor flash: command decode, status polling, id and query modes
// assumes: writes are strobe controlled; busy times shortened for simulation
`timescale 1ns/10ps
module fec_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h1234, // arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h4321, // arbitrary value
   parameter int          PROG_NS  = 2000,
   parameter int          ERASE_NS = 6000
)
(
   input wire logic        ce_n,
   input wire logic        oe_n,
   input wire logic        we_n,
   input wire logic [18:0] addr,
   input wire logic [15:0] dq_in,
   output logic [15:0]     dq_out
);
   logic [15:0] mem [int];
   int          step, kind;
   bit          id_m, qry_m, tog;
   logic [18:0] la;
   logic [15:0] pd, last, v;
   realtime     t_fall, t_done;
   initial begin
      t_done = -1.0e6;
      last = 16'hA5A5;
      dq_out = 16'h5A5A;
   end
   function automatic logic [15:0] arr(int a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction : arr
   task automatic busy(int k, int ns);
      kind = k;
      #(ns);
      kind = 0;
      t_done = $realtime;
   endtask : busy
   task automatic wr(logic [18:0] fa, logic [15:0] d);
      logic [14:0] a;
      a = fa[14:0];
      if (step == 3) begin
         pd = d;
         mem[fa] = arr(fa) & d;
         step = 0;
         fork busy(1, PROG_NS); join_none
      end else if (step == 6 && (d[7:0] == 8'h30 || d[7:0] == 8'h50
                  || (d[7:0] == 8'h10 && a == 15'h5555))) begin
         case (d[7:0])
            8'h30: for (int i = 0; i < 2048; i++) mem.delete({fa[18:11], 11'h0} + i);
            8'h50: for (int i = 0; i < 32768; i++) mem.delete({fa[18:15], 15'h0} + i);
            default: mem.delete();
         endcase
         step = 0;
         fork busy(2, ERASE_NS); join_none
      end else if (d[7:0] == 8'hF0 && (step == 0 || (step == 2 && a == 15'h5555))) begin
         id_m = 0;
         qry_m = 0;
         step = 0;
      end else if (step == 0 && a == 15'h0055 && d[7:0] == 8'h98) qry_m = 1;
      else if ((step == 0 || step == 4) && a == 15'h5555 && d[7:0] == 8'hAA) step++;
      else if ((step == 1 || step == 5) && a == 15'h2AAA && d[7:0] == 8'h55) step++;
      else if (step == 2 && a == 15'h5555 && d[7:0] == 8'hA0) step = 3;
      else if (step == 2 && a == 15'h5555 && d[7:0] == 8'h80) step = 4;
      else if (step == 2 && a == 15'h5555 && d[7:0] == 8'h90) begin
         id_m = 1;
         step = 0;
      end else if (step == 2 && a == 15'h5555 && d[7:0] == 8'h98) begin
         qry_m = 1;
         step = 0;
      end else step = 0;
   endtask : wr
   always @(negedge we_n) begin
      la = addr;
      t_fall = $realtime;
   end
   // busy, unselected, gated or glitch writes are dropped whole
   always @(posedge we_n) begin
      if (!ce_n && oe_n && $realtime - t_fall >= 5.0 && kind == 0) wr(la, dq_in);
   end
   always @(negedge oe_n) if (!ce_n && kind != 0) tog = !tog;
   always @(oe_n or ce_n or addr or kind or tog) begin
      if (!ce_n && !oe_n) begin
         if (kind == 2) v = {~last[15:8], 1'b0, tog, ~last[5:0]};
         else if (kind == 1) v = {~last[15:8], ~pd[7], tog, ~last[5:0]};
         else if (id_m) v = addr[18:1] != 0 ? arr(addr) : addr[0] ? DEV_CODE : MFR_CODE;
         else if (qry_m) v = {8'h5A, addr[7:0]};
         else v = arr(addr);
         if (kind == 0 && $realtime - t_done < 1000.0) v[5:0] = ~v[5:0];
         last = v;
         dq_out = v;
      end else dq_out = ~last;
   end
endmodule : fec_flash_model

// ==== sim/flash_erase_status_command_logic_test.sv ====
// self-checking bench: controller driving the behavioural flash model
// assumes: package, interface, design, checker and model compiled first
`timescale 1ns/10ps
module flash_erase_status_command_logic_test;
   import fec_pkg::*;
   localparam logic [15:0] MFR  = 16'h1234; // arbitrary value
   localparam logic [15:0] DEV  = 16'h4321; // arbitrary value
   localparam int          CEIL = 80000;
   logic               sys_clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_ok;
   logic               mode_query, mode_id, ce_n, oe_n, we_n, dq_oe;
   fec_op_t            cmd_op;
   logic [ADDR_W-1:0]  cmd_addr, f_addr, a;
   logic [DATA_W-1:0]  cmd_data, rsp_data, dq_o, dq_m, d;
   wire  [DATA_W-1:0]  dq_bus = dq_oe ? dq_o : dq_m;
   logic [31:0]        rs = 32'h1F6C;
   logic [31:0]        r;
   int                 miscompares, n_tests, cycles;
   int                 mm [int];
   fec_ctrl #(.POLL_LIMIT(5000)) uut (.sys_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr,
      .cmd_data, .cmd_ready, .rsp_valid, .rsp_ok, .rsp_data, .mode_query, .mode_id,
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(f_addr),
      .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus));
   fec_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.ce_n, .oe_n, .we_n,
      .addr(f_addr), .dq_in(dq_bus), .dq_out(dq_m));
   initial begin
      sys_clk = 0;
      forever #2 sys_clk = ~sys_clk;
   end
   function logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   function logic [15:0] rd(int k);
      return mm.exists(k) ? 16'(mm[k]) : 16'hFFFF;
   endfunction : rd
   task check(logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task give_verdict();
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == CEIL) begin
         miscompares++;
         give_verdict();
      end
   end
   task run(fec_op_t op, logic [18:0] ad, logic [15:0] dt);
      int n;
      n = 0;
      cmd_op <= op;
      cmd_addr <= ad;
      cmd_data <= dt;
      cmd_valid <= 1'b1;
      do @(posedge sys_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20000);
      if (n >= 20000) miscompares++;
   endtask : run
   task rdchk(logic [18:0] ad);
      run(FEC_OP_READ, ad, 16'h0);
      check(rsp_data, rd(ad));
   endtask : rdchk
   task prog(logic [18:0] ad, logic [15:0] dt);
      logic [15:0] e;
      e = rd(ad) & dt;
      mm[ad] = e;
      run(FEC_OP_PROGRAM, ad, dt);
      check(rsp_data, e);
      check({15'h0, rsp_ok}, {15'h0, e == dt});
   endtask : prog
   task erase(fec_op_t op, int sh, logic [18:0] ad);
      int          q[$];
      logic [18:0] b;
      b = ad ^ 19'h40000;
      prog(ad, 16'h0F0F);
      prog(b, 16'h3C3C);
      run(op, ad, 16'h0);
      check(rsp_data, 16'hFFFF);
      check({15'h0, rsp_ok}, 16'h1);
      foreach (mm[k]) if ((k >> sh) == (ad >> sh)) q.push_back(k);
      foreach (q[i]) mm.delete(q[i]);
      rdchk(ad);
      rdchk(b);
   endtask : erase
   task mode_chk(fec_op_t op, logic [18:0] ad, logic [15:0] e, logic qm, logic im);
      run(op, ad, 16'h0);
      @(posedge sys_clk);
      check({14'h0, mode_query, mode_id}, {14'h0, qm, im});
      if (qm | im) begin
         run(FEC_OP_READ, ad, 16'h0);
         check(rsp_data, e);
      end
   endtask : mode_chk
   initial begin
      cmd_valid = 1'b0;
      cmd_op = FEC_OP_READ;
      cmd_addr = '0;
      cmd_data = '0;
      sys_rst = 1'b1;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         a = r[18:0];
         r = rnd();
         d = r[15:0];
         prog(a, d);
         rdchk(a);
      end
      // bit 7 cleared so the overprogrammed word can still show completion
      prog(a, ~d & 16'hFF7F);
      erase(FEC_OP_SECTOR, 11, a);
      erase(FEC_OP_BLOCK, 15, a ^ 19'h00800);
      erase(FEC_OP_CHIP, 19, a);
      mode_chk(FEC_OP_ID_ENTRY, 19'h0, MFR, 1'b0, 1'b1);
      mode_chk(FEC_OP_ID_ENTRY, 19'h1, DEV, 1'b0, 1'b1);
      mode_chk(FEC_OP_EXIT_SHORT, 19'h0, 16'h0, 1'b0, 1'b0);
      rdchk(a);
      mode_chk(FEC_OP_VQUERY, 19'h16, 16'h5A16, 1'b1, 1'b0);
      mode_chk(FEC_OP_EXIT_LONG, 19'h0, 16'h0, 1'b0, 1'b0);
      mode_chk(FEC_OP_GQUERY, 19'h27, 16'h5A27, 1'b1, 1'b0);
      mode_chk(FEC_OP_EXIT_SHORT, 19'h0, 16'h0, 1'b0, 1'b0);
      rdchk(a ^ 19'h00800);
      give_verdict();
   end
endmodule : flash_erase_status_command_logic_test
